// ---- shared/cne_pkg.sv ----
/*
  Shared constants and types for the CAN node error and message object block.
  Assumes a 32-bit APB slave and a protocol core on the same clock.
*/
package cne_pkg;
  // Register byte offsets
  localparam logic [7:0] CNE_CTRL_OFS = 8'h00;
  localparam logic [7:0] CNE_STAT_OFS = 8'h04;
  localparam logic [7:0] CNE_OBJ_OFS = 8'h08;
  localparam logic [7:0] CNE_CNT_OFS = 8'h0C;
  localparam logic [7:0] CNE_WARN_OFS = 8'h10;
  localparam logic [7:0] CNE_IRQ_OFS = 8'h14;
  localparam logic [7:0] CNE_MASK_OFS = 8'h18;
  localparam logic [7:0] CNE_TSTAMP_OFS = 8'h1C;
  // Control bits
  localparam int CNE_CTRL_DIS = 0;
  localparam int CNE_CTRL_HOLD = 1;
  localparam int CNE_CTRL_SDT = 2;
  localparam int CNE_CTRL_STT = 3;
  localparam int CNE_CTRL_W = 4;
  // Status bits
  localparam int CNE_ST_ERROR_WARNING_STATUS = 0;
  localparam int CNE_ST_BUS_OFF_STATUS = 1;
  localparam int CNE_ST_SUSPEND_ACKNOWLEDGE = 2;
  localparam int CNE_ST_IDLE = 3;
  // Message object bits
  localparam int CNE_OBJ_VALID = 0;
  localparam int CNE_OBJ_TRANSMIT_REQUEST = 1;
  localparam int CNE_OBJ_NEW_DATA_FLAG = 2;
  localparam int CNE_OBJ_LOST = 3;
  localparam int CNE_OBJ_W = 4;
  // Interrupt event bits
  localparam int CNE_EV_WARN = 0;
  localparam int CNE_EV_BUS_OFF_STATUS = 1;
  localparam int CNE_EV_PREWARN = 2;
  localparam int CNE_EV_ALERT = 3;
  localparam int CNE_EV_LOST = 4;
  localparam int CNE_EV_TXOK = 5;
  localparam int CNE_EV_RXOK = 6;
  localparam int CNE_IRQ_W = 7;
  // Counter field position and reset values
  localparam int CNE_CNT_REC_LSB = 16;
  localparam logic [7:0] CNE_WARN_RST = 8'h60;
  localparam logic [7:0] CNE_PREWARN_REC = 8'h60;
  localparam logic [8:0] CNE_TEC_LIMIT = 9'h0FF;
  localparam logic [8:0] CNE_TEC_STEP = 9'h008;
  localparam logic [7:0] CNE_BUS_OFF_STATUS_CNT = 8'h01;
  localparam logic [7:0] CNE_RECOV_IDLES = 8'h80;
  localparam logic [3:0] CNE_IDLE_BITS = 4'hB;
  // Events from the protocol core, one-cycle pulses
  typedef struct packed {
    logic bit_tick;
    logic tx_err;
    logic rx_err;
    logic tx_ok;
    logic rx_ok;
    logic rx_data;
    logic rx_remote;
    logic tx_sel;
  } cne_ev_s;
  // Levels back to the protocol core
  typedef struct packed {
    logic node_off;
    logic tx_pending;
    logic single_trial;
  } cne_core_s;
  typedef enum logic [1:0] {
    CNE_ACTIVE = 2'b01,
    CNE_RECOVER = 2'b10
  } cne_state_e;
endpackage

// ---- verilog/cne_idle_det.sv ----
/*
  Receive line synchroniser and bus idle detector.
  Assumes bit_tick marks each sample point of the actual bit time.
*/
`timescale 1ns/1ps
module cne_idle_det (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic rx_pin_in,
  input wire logic bit_tick_in,
  output logic idle_pulse_out,
  output logic bus_idle_out
);
  import cne_pkg::*;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic [3:0] run_reg;

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin_in;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Count recessive samples; every full run of eleven is one idle period
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      run_reg <= 4'h0;
      idle_pulse_out <= 1'b0;
      bus_idle_out <= 1'b0;
    end else begin
      idle_pulse_out <= 1'b0;
      if (bit_tick_in) begin
        if (!rx_sync_reg) begin
          run_reg <= 4'h0; // Dominant bit breaks the run
          bus_idle_out <= 1'b0;
        end else if (run_reg == CNE_IDLE_BITS - 4'h1) begin
          run_reg <= 4'h0;
          idle_pulse_out <= 1'b1;
          bus_idle_out <= 1'b1;
        end else begin
          run_reg <= run_reg + 4'h1;
        end
      end
    end
  end
endmodule

// ---- verilog/cne_msg_obj.sv ----
/*
  One message object: valid, transmit request, new data and lost flags.
  Assumes core events are single-cycle pulses and never coincide per kind.
*/
`timescale 1ns/1ps
module cne_msg_obj (
  input wire logic clk_in,
  input wire logic nrst_in,
  input cne_pkg::cne_ev_s ev_in,
  input wire logic sdt_in,
  input wire logic stt_in,
  input wire logic wr_in,
  input wire logic [cne_pkg::CNE_OBJ_W-1:0] wdata_in,
  output logic [cne_pkg::CNE_OBJ_W-1:0] obj_out,
  output logic lost_ev_out
);
  import cne_pkg::*;
  logic valid_reg;
  logic transmit_request_reg;
  logic new_data_flag_reg;
  logic lost_reg;
  logic extra_reg;

  assign obj_out = {lost_reg, new_data_flag_reg, transmit_request_reg, valid_reg};

  // Software writes first, hardware events after so that hardware events win
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      valid_reg <= 1'b0;
      transmit_request_reg <= 1'b0;
      new_data_flag_reg <= 1'b0;
      lost_reg <= 1'b0;
      extra_reg <= 1'b0;
      lost_ev_out <= 1'b0;
    end else begin
      lost_ev_out <= 1'b0;
      if (wr_in) begin
        valid_reg <= wdata_in[CNE_OBJ_VALID];
        transmit_request_reg <= wdata_in[CNE_OBJ_TRANSMIT_REQUEST];
        new_data_flag_reg <= wdata_in[CNE_OBJ_NEW_DATA_FLAG];
        lost_reg <= wdata_in[CNE_OBJ_LOST];
        extra_reg <= 1'b0;
      end
      if (valid_reg && ev_in.rx_data) begin
        new_data_flag_reg <= 1'b1;
        if (new_data_flag_reg) begin
          lost_reg <= 1'b1;
          lost_ev_out <= 1'b1;
        end
        if (sdt_in) valid_reg <= 1'b0;
      end
      if (valid_reg && ev_in.rx_remote) begin
        transmit_request_reg <= 1'b1;
        new_data_flag_reg <= transmit_request_reg;
        if (sdt_in) valid_reg <= 1'b0;
      end
      // Single trial drops the request on selection, so errors never retry
      if (ev_in.tx_sel && stt_in) transmit_request_reg <= 1'b0;
      if (ev_in.tx_ok) begin
        if (sdt_in) begin
          valid_reg <= 1'b0;
          transmit_request_reg <= 1'b0;
        end else if (new_data_flag_reg && !extra_reg && !stt_in) begin
          extra_reg <= 1'b1; // keep one more frame queued
        end else begin
          transmit_request_reg <= 1'b0; // one frame per request
          new_data_flag_reg <= 1'b0;
          extra_reg <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- verilog/cne_top.sv ----
/*
  CAN node error handling, bus-off recovery, node disable and one message
  object, with an APB register file and a level interrupt.
  Assumes the protocol core runs on clk_in and reports its events as
  one-cycle pulses; the receive pin is asynchronous.
*/
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module cne_top (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_pin_in,
  input cne_pkg::cne_ev_s ev_in,
  output cne_pkg::cne_core_s core_out,
  output logic irq_out
);
  import cne_pkg::*;

  // Word-aligned address check used by write enable and error answer
  function automatic logic cne_mapped(input logic [7:0] a);
    cne_mapped = (a[1:0] == 2'b00) && (a <= CNE_TSTAMP_OFS);
  endfunction

  // Down-count that stops at zero
  function automatic logic [8:0] cne_dec(input logic [8:0] v);
    cne_dec = (v == 9'h000) ? v : v - 9'h001;
  endfunction

  logic [CNE_CTRL_W-1:0] ctrl_reg;
  logic [7:0] warn_lvl_reg;
  logic [CNE_IRQ_W-1:0] irq_stat_reg;
  logic [CNE_IRQ_W-1:0] irq_mask_reg;
  logic [15:0] tstamp_reg;
  logic suspend_acknowledge_reg;
  cne_state_e state_reg;
  logic [8:0] tec_reg;
  logic [8:0] tec_next;
  logic [7:0] rec_reg;
  logic [8:0] rec_next;
  logic [7:0] idles_reg;
  logic error_warning_status_reg;
  logic error_warning_status_next;
  logic bus_off_status_reg;
  logic ev_warn_reg;
  logic ev_bus_off_status_reg;
  logic ev_pre_reg;
  logic ev_alert_reg;
  logic idle_pulse;
  logic bus_idle;
  logic [CNE_OBJ_W-1:0] obj;
  logic lost_ev;
  logic acc_done;
  logic wr_en;
  logic rd_irq;
  logic [CNE_IRQ_W-1:0] irq_ev;
  logic [31:0] rd_mux;
  logic wr_ctrl;
  logic wr_warn;
  logic wr_mask;
  logic wr_obj;
  logic [CNE_IRQ_W-1:0] irq_clr;
  logic [7:0] rec_inc;
  logic [7:0] idles_inc;

  cne_idle_det u_idle (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .rx_pin_in(rx_pin_in),
    .bit_tick_in(ev_in.bit_tick),
    .idle_pulse_out(idle_pulse),
    .bus_idle_out(bus_idle)
  );

  cne_msg_obj u_obj (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ev_in(ev_in),
    .sdt_in(ctrl_reg[CNE_CTRL_SDT]),
    .stt_in(ctrl_reg[CNE_CTRL_STT]),
    .wr_in(wr_obj),
    .wdata_in(pwdata_in[CNE_OBJ_W-1:0]),
    .obj_out(obj),
    .lost_ev_out(lost_ev)
  );

  // APB handshake: one wait-free access cycle after setup
  assign acc_done = psel_in && penable_in && pready_out;
  assign wr_en = acc_done && pwrite_in && cne_mapped(paddr_in);
  assign rd_irq = acc_done && !pwrite_in && paddr_in == CNE_IRQ_OFS;

  // One strobe per writable register; read-only offsets get none, so a
  // write there is dropped without an error answer
  assign wr_ctrl = wr_en && paddr_in == CNE_CTRL_OFS;
  assign wr_warn = wr_en && paddr_in == CNE_WARN_OFS;
  assign wr_mask = wr_en && paddr_in == CNE_MASK_OFS;
  assign wr_obj = wr_en && paddr_in == CNE_OBJ_OFS;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !cne_mapped(paddr_in);
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= rd_mux;
      end
    end
  end

  // Read data is captured in setup, so it shows state one cycle early
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr_in)
      CNE_CTRL_OFS: rd_mux[CNE_CTRL_W-1:0] = ctrl_reg;
      CNE_STAT_OFS: rd_mux[CNE_ST_IDLE:0] = {bus_idle, suspend_acknowledge_reg, bus_off_status_reg, error_warning_status_reg};
      CNE_OBJ_OFS: rd_mux[CNE_OBJ_W-1:0] = obj;
      CNE_CNT_OFS: begin
        rd_mux[8:0] = tec_reg;
        rd_mux[CNE_CNT_REC_LSB +: 8] = rec_reg;
      end
      CNE_WARN_OFS: rd_mux[7:0] = warn_lvl_reg;
      CNE_IRQ_OFS: rd_mux[CNE_IRQ_W-1:0] = irq_stat_reg;
      CNE_MASK_OFS: rd_mux[CNE_IRQ_W-1:0] = irq_mask_reg;
      CNE_TSTAMP_OFS: rd_mux[15:0] = tstamp_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Control and configuration; bus-off forces the hold bit on
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl_reg <= 4'h0;
      warn_lvl_reg <= CNE_WARN_RST;
      irq_mask_reg <= 7'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata_in[CNE_CTRL_W-1:0];
      end
      if (wr_warn) begin
        warn_lvl_reg <= pwdata_in[7:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= pwdata_in[CNE_IRQ_W-1:0];
      end
      if (ev_bus_off_status_reg) begin
        ctrl_reg[CNE_CTRL_HOLD] <= 1'b1;
      end
    end
  end

  // Suspend acknowledge only once the bus has gone idle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      suspend_acknowledge_reg <= 1'b0;
    end else begin
      suspend_acknowledge_reg <= ctrl_reg[CNE_CTRL_DIS] && (suspend_acknowledge_reg || bus_idle);
    end
  end

  // Time stamp follows actual bit times, so resync stretches it
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tstamp_reg <= 16'h0000;
    end else if (ev_in.bit_tick) begin
      tstamp_reg <= tstamp_reg + 16'h0001;
    end
  end

  // Error counter steps while the node is active
  always_comb begin
    tec_next = tec_reg;
    rec_next = {1'b0, rec_reg};
    if (ev_in.tx_err) begin
      tec_next = tec_reg + CNE_TEC_STEP;
    end else if (ev_in.tx_ok) begin
      tec_next = cne_dec(tec_reg);
    end
    if (ev_in.rx_err && rec_reg != 8'hFF) begin
      rec_next = {1'b0, rec_reg} + 9'h001;
    end else if (ev_in.rx_ok) begin
      rec_next = cne_dec({1'b0, rec_reg});
    end
    error_warning_status_next = (tec_next >= {1'b0, warn_lvl_reg}) || (rec_next >= {1'b0, warn_lvl_reg});
  end

  // Recovery steps, shared by the threshold compares and the updates
  assign rec_inc = rec_reg + 8'h01;
  assign idles_inc = idles_reg + 8'h01;

  // Node state: active, or bus-off with automatic recovery
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= CNE_ACTIVE;
      tec_reg <= 9'h000;
      rec_reg <= 8'h00;
      idles_reg <= 8'h00;
      error_warning_status_reg <= 1'b0;
      bus_off_status_reg <= 1'b0;
      ev_warn_reg <= 1'b0;
      ev_bus_off_status_reg <= 1'b0;
      ev_pre_reg <= 1'b0;
      ev_alert_reg <= 1'b0;
    end else begin
      ev_warn_reg <= 1'b0;
      ev_bus_off_status_reg <= 1'b0;
      ev_pre_reg <= 1'b0;
      ev_alert_reg <= 1'b0;
      unique case (state_reg)
        CNE_ACTIVE: begin
          if (tec_next > CNE_TEC_LIMIT) begin
            state_reg <= CNE_RECOVER;
            tec_reg <= {1'b0, CNE_BUS_OFF_STATUS_CNT};
            rec_reg <= CNE_BUS_OFF_STATUS_CNT;
            bus_off_status_reg <= 1'b1;
            error_warning_status_reg <= 1'b0;
            ev_bus_off_status_reg <= 1'b1;
            idles_reg <= 8'h00;
          end else begin
            tec_reg <= tec_next;
            rec_reg <= rec_next[7:0];
            error_warning_status_reg <= error_warning_status_next;
            ev_warn_reg <= error_warning_status_next && !error_warning_status_reg;
          end
        end
        CNE_RECOVER: begin
          // Recovery needs no software start; idle periods drive it
          if (idle_pulse) begin
            rec_reg <= rec_inc;
            idles_reg <= idles_inc;
            if (rec_inc == CNE_PREWARN_REC) begin
              error_warning_status_reg <= 1'b1;
              ev_pre_reg <= 1'b1;
            end
            if (idles_inc == CNE_RECOV_IDLES) begin
              state_reg <= CNE_ACTIVE; // hold bit stays set
              tec_reg <= 9'h000;
              rec_reg <= 8'h00;
              error_warning_status_reg <= 1'b0;
              bus_off_status_reg <= 1'b0;
              ev_alert_reg <= 1'b1;
            end
          end
        end
        default: state_reg <= CNE_ACTIVE;
      endcase
    end
  end

  assign irq_ev = {ev_in.rx_ok, ev_in.tx_ok, lost_ev, ev_alert_reg, ev_pre_reg, ev_bus_off_status_reg, ev_warn_reg};

  // A read clears only the bits it returned at setup; an event that lands
  // between setup and access stays pending instead of being lost
  assign irq_clr = rd_irq ? prdata_out[CNE_IRQ_W-1:0] : 7'h00;

  // Sticky status cleared by reading it; a new event in that cycle survives
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_stat_reg <= 7'h00;
      irq_out <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Core view; the disable bit reaches the core only through the suspend
  // acknowledge, which is what makes a short disable request harmless
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      core_out <= '0;
    end else begin
      core_out.node_off <= bus_off_status_reg || ctrl_reg[CNE_CTRL_HOLD] || suspend_acknowledge_reg;
      core_out.tx_pending <= obj[CNE_OBJ_VALID] && obj[CNE_OBJ_TRANSMIT_REQUEST];
      core_out.single_trial <= ctrl_reg[CNE_CTRL_STT];
    end
  end
endmodule

// ---- verification/cne_top_asserts.sv ----
/*
  Checker for cne_top: APB handshake and control-to-core relations.
  Assumes it is bound to cne_top and sees only its ports.
*/
`timescale 1ns/1ps
module cne_top_asserts (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire cne_pkg::cne_ev_s ev_in,
  input wire cne_pkg::cne_core_s core_out
);
  import cne_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Bus phases shared by the properties below
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  sequence ctrl_wr_s;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == CNE_CTRL_OFS;
  endsequence
  chk_ready_after_setup: assert property (setup_s |=> pready_out)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  chk_error_unmapped: assert property (setup_s ##0 paddr_in > 8'h1C |=> pslverr_out && pready_out)
    else $error("unmapped access not refused");
  chk_mapped_clean: assert property (setup_s ##0 (paddr_in <= 8'h1C && paddr_in[1:0] == 2'h0) |=> !pslverr_out)
    else $error("mapped access refused");
  chk_error_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  // Core must see the trial mode within two edges of the write
  chk_trial_follows: assert property (ctrl_wr_s ##0 pwdata_in[CNE_CTRL_STT] |=> ##[0:1] core_out.single_trial)
    else $error("single trial not passed to core");
  chk_hold_offline: assert property (ctrl_wr_s ##0 pwdata_in[CNE_CTRL_HOLD] |=> ##[0:1] core_out.node_off)
    else $error("hold bit does not take node off");
  chk_trial_drop: assert property (core_out.single_trial && ev_in.tx_sel |=> ##[0:1] !core_out.tx_pending)
    else $error("request kept after selection");
endmodule
bind cne_top cne_top_asserts u_chk (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .ev_in(ev_in),
  .core_out(core_out)
);

// ---- verification/cne_bus_model.sv ----
/*
  Model of the other nodes: receive line level and bit sample ticks.
  Assumes the bench gates ticks and chooses idle or frame traffic.
*/
`timescale 1ns/1ps
module cne_bus_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic tick_en_in,
  input wire logic recessive_in,
  output logic rx_pin_out,
  output logic bit_tick_out,
  output logic [15:0] ticks_out
);
  logic [2:0] div_reg;
  logic long_reg;
  // Bit time alternates 4 and 5 clocks, as resync stretches bits
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !tick_en_in) begin
      div_reg <= 3'h0;
      bit_tick_out <= 1'b0;
    end else if (div_reg == (long_reg ? 3'h4 : 3'h3)) begin
      div_reg <= 3'h0;
      bit_tick_out <= 1'b1;
    end else begin
      div_reg <= div_reg + 3'h1;
      bit_tick_out <= 1'b0;
    end
  end
  // Tick count lets the bench predict the time stamp
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ticks_out <= 16'h0;
      long_reg <= 1'b0;
    end else if (bit_tick_out) begin
      ticks_out <= ticks_out + 16'h1;
      long_reg <= !long_reg;
    end
  end
  // Frame traffic never gives eleven recessive bits in a row
  always_ff @(posedge clk_in) begin
    rx_pin_out <= recessive_in | (ticks_out[0] & ticks_out[1]);
  end
endmodule

// ---- verification/cne_top_tb.sv ----
/*
  Testbench for cne_top: APB tasks, core event pulses, bus model.
  Assumes nothing of APB wait states; the master waits for ready.
*/
`timescale 1ns/1ps
module cne_top_tb;
  import cne_pkg::*;
  logic clk, nrst, psel, pen, pwr, rec, ten, prdy, perr, irq, rxp, tick, err;
  logic [7:0] paddr, evb;
  logic [31:0] pwd, prd, rd;
  logic [15:0] nt, t0, s0;
  logic [15:0] tbl [7] = '{16'h4124, 16'h4424, 16'h4112, 16'h4340, 16'h052D, 16'h0513, 16'h8301};
  cne_ev_s ev;
  cne_core_s core;
  int n_fail = 0;
  int tests_run = 0;
  assign ev = cne_ev_s'({tick, evb[6:0]});
  cne_top DUT (.clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .rx_pin_in(rxp), .ev_in(ev), .core_out(core), .irq_out(irq));
  cne_bus_model u_bus (.clk_in(clk), .nrst_in(nrst), .tick_en_in(ten), .recessive_in(rec),
    .rx_pin_out(rxp), .bit_tick_out(tick), .ticks_out(nt));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task stop_test;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until ready is seen high at a rising edge; the watchdog
  // is the only limit on the wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task pulse(input int b);
    @(posedge clk);
    evb[b] <= 1'b1;
    @(posedge clk);
    evb <= 8'h00;
  endtask
  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  // Hang guard, well beyond the longest recovery
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    {nrst, psel, pen, pwr, ten} = 5'h00;
    rec = 1'b1;
    paddr = 8'h00;
    pwd = 32'h0;
    evb = 8'h00;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdc("warn", CNE_WARN_OFS, 32'hFF, 32'h60);
    rdc("mask", CNE_MASK_OFS, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, CNE_MASK_OFS, 32'h1);
    repeat (12) pulse(6);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("stat", CNE_STAT_OFS, 32'h1, 32'h1);
    rdc("cnt", CNE_CNT_OFS, 32'h1FF, 32'h60);
    repeat (20) pulse(6);
    repeat (3) @(posedge clk);
    rdc("cnt", CNE_CNT_OFS, 32'hFFFFFFFF, 32'h00010001);
    rdc("stat", CNE_STAT_OFS, 32'h3, 32'h2);
    rdc("ctrl", CNE_CTRL_OFS, 32'h2, 32'h2);
    rdc("irqst", CNE_IRQ_OFS, 32'h3, 32'h3);
    // Recovery on an idle bus
    apb(1'b1, CNE_MASK_OFS, 32'h4);
    ten <= 1'b1;
    wait_irq();
    rdc("stat", CNE_STAT_OFS, 32'h3, 32'h3);
    rdc("rec", CNE_CNT_OFS, 32'hFF0000, 32'h600000);
    rdc("irqst", CNE_IRQ_OFS, 32'h4, 32'h4);
    apb(1'b1, CNE_MASK_OFS, 32'h8);
    wait_irq();
    rdc("stat", CNE_STAT_OFS, 32'h3, 32'h0);
    rdc("ctrl", CNE_CTRL_OFS, 32'h2, 32'h2);
    rdc("cnt", CNE_CNT_OFS, 32'hFFFFFFFF, 32'h0);
    rdc("irqst", CNE_IRQ_OFS, 32'h8, 32'h8);
    // Disable waits for the bus to go idle
    // Frame traffic must clear the idle flag before the disable lands
    rec <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b1, CNE_CTRL_OFS, 32'h3);
    repeat (60) @(posedge clk);
    rdc("suspend_acknowledge", CNE_STAT_OFS, 32'hC, 32'h0);
    rec <= 1'b1;
    repeat (120) @(posedge clk);
    rdc("suspend_acknowledge", CNE_STAT_OFS, 32'hC, 32'hC);
    ten <= 1'b0;
    // Object table: control, initial flags, event, expected flags
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, CNE_CTRL_OFS, {28'h0, tbl[i][15:12]});
      apb(1'b1, CNE_OBJ_OFS, {28'h0, tbl[i][11:8]});
      pulse(int'(tbl[i][7:4]));
      rdc("obj", CNE_OBJ_OFS, 32'hF, {28'h0, tbl[i][3:0]});
    end
    rdc("irqev", CNE_IRQ_OFS, 32'h70, 32'h30);
    pulse(6);
    rdc("retry", CNE_OBJ_OFS, 32'h2, 32'h0);
    apb(1'b1, CNE_CTRL_OFS, 32'h0);
    apb(1'b1, CNE_OBJ_OFS, 32'h1);
    pulse(1);
    rdc("remote1", CNE_OBJ_OFS, 32'hF, 32'h3);
    pulse(1);
    rdc("remote2", CNE_OBJ_OFS, 32'h6, 32'h6);
    pulse(4);
    rdc("extra", CNE_OBJ_OFS, 32'h2, 32'h2);
    pulse(4);
    rdc("done", CNE_OBJ_OFS, 32'h2, 32'h0);
    // Stamp advances by bit times actually seen
    t0 = nt;
    apb(1'b0, CNE_TSTAMP_OFS, 32'h0);
    s0 = rd[15:0];
    ten <= 1'b1;
    repeat (60) @(posedge clk);
    ten <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, CNE_TSTAMP_OFS, 32'h0);
    chk("stamp", {16'h0, nt - t0}, {16'h0, rd[15:0] - s0});
    stop_test();
  end
endmodule
